// [verilog/thermal_pkg.sv]
// Constants for the thermal overload estimator: register map, fields, defaults and model scaling.
package thermal_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int HEAT_W = 16;
  localparam int CURR_W = 16;
  localparam int CNT_W  = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_KFACTOR   = 8'h04;
  localparam logic [7:0] OFS_ALARM     = 8'h08;
  localparam logic [7:0] OFS_HIGH      = 8'h0c;
  localparam logic [7:0] OFS_TRIP      = 8'h10;
  localparam logic [7:0] OFS_TAU_HEAT  = 8'h14;
  localparam logic [7:0] OFS_TAU_COOL  = 8'h18;
  localparam logic [7:0] OFS_HOT_LEVEL = 8'h1c;
  localparam logic [7:0] OFS_STATUS    = 8'h20;
  localparam logic [7:0] OFS_HOTTEST   = 8'h24;
  localparam logic [7:0] OFS_PHASE1    = 8'h28;
  localparam logic [7:0] OFS_PHASE2    = 8'h2c;
  localparam logic [7:0] OFS_PHASE3    = 8'h30;
  localparam logic [7:0] OFS_PICKUPS   = 8'h34;
  localparam logic [7:0] OFS_TRIPS     = 8'h38;

  // Control register fields
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_OP_ON   = 1;
  localparam int CTRL_HI_MODE = 2;
  localparam int CTRL_MACHINE = 3;
  localparam int CTRL_BLK_LSB = 4;
  localparam int CTRL_W       = 7;

  // Status register fields
  localparam int ST_ALARM   = 0;
  localparam int ST_TRIP    = 1;
  localparam int ST_HIGH    = 2;
  localparam int ST_HOT     = 3;
  localparam int ST_INHIBIT = 4;

  // Settings: k-factor in hundredths of In, temperatures in counts (1000 = 100 %), tau in tenths of a minute
  localparam logic [15:0] KFAC_MIN  = 16'h000a;
  localparam logic [15:0] KFAC_DEF  = 16'h006e;
  localparam logic [15:0] KFAC_MAX  = 16'h0190;
  localparam logic [15:0] LVL_MIN   = 16'h01c2;
  localparam logic [15:0] LVL_MAX   = 16'h03de;
  localparam logic [15:0] ALARM_DEF = 16'h0384;
  localparam logic [15:0] HIGH_DEF  = 16'h03b6;
  localparam logic [15:0] TRIP_DEF  = 16'h03e8;
  localparam logic [15:0] HOT_DEF   = 16'h01f4;
  localparam logic [15:0] TAU_MIN   = 16'h000a;
  localparam logic [15:0] TAU_DEF   = 16'h03e8;
  localparam logic [15:0] TAU_MAX   = 16'h2710;

  // Model scaling: current 1000 = 1.0 In, temperature 1000 counts = 100 %
  localparam int  CURR_UNIT      = 1000;
  localparam int  KFAC_TO_CURR   = 10;
  localparam int  SAMPLE_US      = 1000;
  localparam int  TENTH_MIN_US   = 6000000;
  localparam int  ALPHA_FRAC     = 40;
  localparam int  ALPHA_W        = 28;
  localparam longint ALPHA_NUM_L = (64'd1 <<< ALPHA_FRAC) * SAMPLE_US / TENTH_MIN_US;
  localparam logic [ALPHA_W-1:0] ALPHA_NUM = ALPHA_NUM_L[ALPHA_W-1:0];
  localparam int  DIV_CNT_W      = 5;

  typedef enum logic [0:0] {
    DIV_HEAT = 1'b0,
    DIV_COOL = 1'b1
  } div_sel_t;
endpackage

// [verilog/thermal_overload_estimator.sv]
// Thermal overload estimator: per-phase first-order heating model, protection flags and register port.
//
// Summary of operation
// - Three phase estimates, hottest one is monitored
// - Alarm and trip when hottest reaches settings
// - Temperature tends exponentially to squared current ratio
// - Start-on-trip: high signal with trip
// - Start-on-high: high signal at high setting
// - Close inhibit until below high setting
// - Trip drops once breaker opens after trip
// - Flags only when enabled and mode on; model always runs
// - k-factor 0,1 to 4,0, default 1,10
// - Alarm/high 45 to 99 percent, defaults 90/95
// - Time constant 1 to 1000 minutes, default 100
// - Pickup blocked by none or user variable
// - Temperatures published, 1000 counts per 100 percent
// - Pickup and trip events counted, readable
// - Machine: separate heating and cooling constants
// - Machine: max current is service factor times In
// - Machine: trip needs overcurrent and overtemperature
// - Machine: one hot-state output, hottest above hot level
// - Phase outputs zero at startup, loadable
`timescale 1ns/1ps
`default_nettype none

module thermal_overload_estimator
  import thermal_pkg::*;
(
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_sample_valid,
  input  wire logic [thermal_pkg::CURR_W-1:0] i_phase_current_a,
  input  wire logic [thermal_pkg::CURR_W-1:0] i_phase_current_b,
  input  wire logic [thermal_pkg::CURR_W-1:0] i_phase_current_c,
  input  wire logic                       i_breaker_open,
  input  wire logic [3:0]                 i_user_var,
  input  wire logic [thermal_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [thermal_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic [thermal_pkg::DATA_W-1:0]  o_rdata,
  output logic                            o_alarm,
  output logic                            o_trip,
  output logic                            o_high_temp,
  output logic                            o_close_inhibit,
  output logic                            o_hot_state,
  output logic [thermal_pkg::HEAT_W-1:0]  o_phase_heat_output_1,
  output logic [thermal_pkg::HEAT_W-1:0]  o_phase_heat_output_2,
  output logic [thermal_pkg::HEAT_W-1:0]  o_phase_heat_output_3,
  output logic [thermal_pkg::HEAT_W-1:0]  o_hottest_heat
);
  import thermal_pkg::*;

  // ---------------- Settings ----------------
  logic [CTRL_W-1:0] ctrl;
  logic [15:0]       kfactor;
  logic [15:0]       alarm_set;
  logic [15:0]       high_set;
  logic [15:0]       trip_set;
  logic [15:0]       tau_heat;
  logic [15:0]       tau_cool;
  logic [15:0]       hot_level;
  logic [CTRL_W-1:0] next_ctrl;
  logic [15:0]       next_kfactor;
  logic [15:0]       next_alarm_set;
  logic [15:0]       next_high_set;
  logic [15:0]       next_trip_set;
  logic [15:0]       next_tau_heat;
  logic [15:0]       next_tau_cool;
  logic [15:0]       next_hot_level;

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  always_comb begin
    next_ctrl      = ctrl;
    next_kfactor   = kfactor;
    next_alarm_set = alarm_set;
    next_high_set  = high_set;
    next_trip_set  = trip_set;
    next_tau_heat  = tau_heat;
    next_tau_cool  = tau_cool;
    next_hot_level = hot_level;
    if (i_wr) begin
      case (i_addr)
        OFS_CTRL:      next_ctrl      = i_wdata[CTRL_W-1:0];
        OFS_KFACTOR:   next_kfactor   = clamp(i_wdata[15:0], KFAC_MIN, KFAC_MAX);
        OFS_ALARM:     next_alarm_set = clamp(i_wdata[15:0], LVL_MIN, LVL_MAX);
        OFS_HIGH:      next_high_set  = clamp(i_wdata[15:0], LVL_MIN, LVL_MAX);
        OFS_TRIP:      next_trip_set  = i_wdata[15:0];
        OFS_TAU_HEAT:  next_tau_heat  = clamp(i_wdata[15:0], TAU_MIN, TAU_MAX);
        OFS_TAU_COOL:  next_tau_cool  = clamp(i_wdata[15:0], TAU_MIN, TAU_MAX);
        OFS_HOT_LEVEL: next_hot_level = i_wdata[15:0];
        default:       next_ctrl      = ctrl;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl      <= '0;
      kfactor   <= KFAC_DEF;
      alarm_set <= ALARM_DEF;
      high_set  <= HIGH_DEF;
      trip_set  <= TRIP_DEF;
      tau_heat  <= TAU_DEF;
      tau_cool  <= TAU_DEF;
      hot_level <= HOT_DEF;
    end else begin
      ctrl      <= next_ctrl;
      kfactor   <= next_kfactor;
      alarm_set <= next_alarm_set;
      high_set  <= next_high_set;
      trip_set  <= next_trip_set;
      tau_heat  <= next_tau_heat;
      tau_cool  <= next_tau_cool;
      hot_level <= next_hot_level;
    end
  end

  // ---------------- Per-sample decay factors ----------------
  // A divider runs in the background, alternating heating and cooling; a new time constant
  // takes effect within three divisions (about 84 cycles), far below one sample period.
  div_sel_t               div_sel;
  div_sel_t               next_div_sel;
  logic [DIV_CNT_W-1:0]   div_cnt;
  logic [DIV_CNT_W-1:0]   next_div_cnt;
  logic [16:0]            div_rem;
  logic [16:0]            next_div_rem;
  logic [ALPHA_W-1:0]     div_quo;
  logic [ALPHA_W-1:0]     next_div_quo;
  logic [ALPHA_W-1:0]     alpha_heat;
  logic [ALPHA_W-1:0]     alpha_cool;
  logic [ALPHA_W-1:0]     next_alpha_heat;
  logic [ALPHA_W-1:0]     next_alpha_cool;
  logic [16:0]            rem_shift;
  logic [15:0]            divisor;

  always_comb begin
    next_div_sel    = div_sel;
    next_div_cnt    = div_cnt - 5'h01;
    next_alpha_heat = alpha_heat;
    next_alpha_cool = alpha_cool;
    divisor         = (div_sel == DIV_HEAT) ? tau_heat : tau_cool;
    rem_shift       = {div_rem[15:0], ALPHA_NUM[div_cnt]};
    next_div_quo    = div_quo;
    next_div_rem    = rem_shift;
    if (rem_shift >= {1'b0, divisor}) begin
      next_div_rem          = rem_shift - {1'b0, divisor};
      next_div_quo[div_cnt] = 1'b1;
    end
    if (div_cnt == '0) begin
      case (div_sel)
        DIV_HEAT: begin
          next_alpha_heat = next_div_quo;
          next_div_sel    = DIV_COOL;
        end
        DIV_COOL: begin
          next_alpha_cool = next_div_quo;
          next_div_sel    = DIV_HEAT;
        end
        default: next_div_sel = DIV_HEAT;
      endcase
      next_div_cnt = 5'(ALPHA_W - 1);
      next_div_rem = '0;
      next_div_quo = '0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      div_sel    <= DIV_HEAT;
      div_cnt    <= 5'(ALPHA_W - 1);
      div_rem    <= '0;
      div_quo    <= '0;
      alpha_heat <= '0;
      alpha_cool <= '0;
    end else begin
      div_sel    <= next_div_sel;
      div_cnt    <= next_div_cnt;
      div_rem    <= next_div_rem;
      div_quo    <= next_div_quo;
      alpha_heat <= next_alpha_heat;
      alpha_cool <= next_alpha_cool;
    end
  end

  // ---------------- Phase models ----------------
  // Temperatures are kept with 16 fraction bits so slow time constants still move them.
  logic [CURR_W-1:0] curr [3];
  logic [31:0]       temp [3];
  logic [2:0]        over_current;

  assign curr[0] = i_phase_current_a;
  assign curr[1] = i_phase_current_b;
  assign curr[2] = i_phase_current_c;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      logic [31:0]         square;
      logic [31:0]         target_cnt;
      logic [31:0]         target;
      logic signed [32:0]  diff;
      logic                heating;
      logic signed [61:0]  prod;
      logic [31:0]         next_temp;

      always_comb begin
        square     = curr[g] * curr[g];
        target_cnt = square / 32'(CURR_UNIT);
        target     = (target_cnt > 32'h0000ffff) ? 32'hffff0000 : {target_cnt[15:0], 16'h0000};
        diff       = $signed({1'b0, target}) - $signed({1'b0, temp[g]});
        heating    = !diff[32] || !ctrl[CTRL_MACHINE];
        prod       = diff * $signed({1'b0, (heating ? alpha_heat : alpha_cool)});
        next_temp  = temp[g];
        if (i_wr && i_addr == OFS_PHASE1 + 8'(4 * g)) begin
          next_temp = {i_wdata[15:0], 16'h0000};
        end else if (i_sample_valid) begin
          next_temp = 32'($signed({1'b0, temp[g]}) + (prod >>> ALPHA_FRAC));
        end
      end

      always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
          temp[g] <= '0;
        end else begin
          temp[g] <= next_temp;
        end
      end

      assign over_current[g] = curr[g] > 16'(kfactor * 16'(KFAC_TO_CURR));
    end
  endgenerate

  // ---------------- Protection flags and counters ----------------
  logic [HEAT_W-1:0] phase_heat [3];
  logic [HEAT_W-1:0] hottest;
  logic [HEAT_W-1:0] next_hottest;
  logic              blocked;
  logic              active;
  logic              trip_cond;
  logic              trip_done;
  logic              next_trip_done;
  logic              next_alarm;
  logic              next_trip;
  logic              next_high;
  logic              next_hot;
  logic [CNT_W-1:0]  pickups;
  logic [CNT_W-1:0]  trips;
  logic [CNT_W-1:0]  next_pickups;
  logic [CNT_W-1:0]  next_trips;

  always_comb begin
    phase_heat[0] = temp[0][31:16];
    phase_heat[1] = temp[1][31:16];
    phase_heat[2] = temp[2][31:16];
    next_hottest  = phase_heat[0];
    if (phase_heat[1] > next_hottest) begin
      next_hottest = phase_heat[1];
    end
    if (phase_heat[2] > next_hottest) begin
      next_hottest = phase_heat[2];
    end
    case (ctrl[CTRL_BLK_LSB +: 3])
      3'h1:    blocked = i_user_var[0];
      3'h2:    blocked = i_user_var[1];
      3'h3:    blocked = i_user_var[2];
      3'h4:    blocked = i_user_var[3];
      default: blocked = 1'b0;
    endcase
    active     = ctrl[CTRL_ENABLE] && ctrl[CTRL_OP_ON];
    next_alarm = active && !blocked && hottest >= alarm_set;
    trip_cond  = active && !blocked && hottest >= trip_set
                 && (!ctrl[CTRL_MACHINE] || |over_current);
    // Once the breaker has opened on our trip, stay quiet until the temperature leaves the trip zone
    next_trip_done = (o_trip && i_breaker_open) || (trip_done && hottest >= trip_set);
    next_trip      = trip_cond && !next_trip_done;
    if (ctrl[CTRL_HI_MODE]) begin
      next_high = active && hottest >= high_set;
    end else begin
      next_high = active && (next_trip || (o_high_temp && hottest >= high_set));
    end
    next_hot     = active && ctrl[CTRL_MACHINE] && hottest > hot_level;
    next_pickups = (next_alarm && !o_alarm) ? pickups + 16'h0001 : pickups;
    next_trips   = (next_trip && !o_trip) ? trips + 16'h0001 : trips;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      hottest               <= '0;
      trip_done             <= 1'b0;
      o_alarm               <= 1'b0;
      o_trip                <= 1'b0;
      o_high_temp           <= 1'b0;
      o_close_inhibit       <= 1'b0;
      o_hot_state           <= 1'b0;
      pickups               <= '0;
      trips                 <= '0;
      o_phase_heat_output_1 <= '0;
      o_phase_heat_output_2 <= '0;
      o_phase_heat_output_3 <= '0;
      o_hottest_heat        <= '0;
    end else begin
      hottest               <= next_hottest;
      trip_done             <= next_trip_done;
      o_alarm               <= next_alarm;
      o_trip                <= next_trip;
      o_high_temp           <= next_high;
      o_close_inhibit       <= next_high;
      o_hot_state           <= next_hot;
      pickups               <= next_pickups;
      trips                 <= next_trips;
      o_phase_heat_output_1 <= phase_heat[0];
      o_phase_heat_output_2 <= phase_heat[1];
      o_phase_heat_output_3 <= phase_heat[2];
      o_hottest_heat        <= next_hottest;
    end
  end

  // ---------------- Register read port ----------------
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (i_rd) begin
      case (i_addr)
        OFS_CTRL:      next_rdata = {25'h0, ctrl};
        OFS_KFACTOR:   next_rdata = {16'h0, kfactor};
        OFS_ALARM:     next_rdata = {16'h0, alarm_set};
        OFS_HIGH:      next_rdata = {16'h0, high_set};
        OFS_TRIP:      next_rdata = {16'h0, trip_set};
        OFS_TAU_HEAT:  next_rdata = {16'h0, tau_heat};
        OFS_TAU_COOL:  next_rdata = {16'h0, tau_cool};
        OFS_HOT_LEVEL: next_rdata = {16'h0, hot_level};
        OFS_STATUS:    next_rdata = {27'h0, o_close_inhibit, o_hot_state, o_high_temp, o_trip, o_alarm};
        OFS_HOTTEST:   next_rdata = {16'h0, hottest};
        OFS_PHASE1:    next_rdata = {16'h0, phase_heat[0]};
        OFS_PHASE2:    next_rdata = {16'h0, phase_heat[1]};
        OFS_PHASE3:    next_rdata = {16'h0, phase_heat[2]};
        OFS_PICKUPS:   next_rdata = {16'h0, pickups};
        OFS_TRIPS:     next_rdata = {16'h0, trips};
        default:       next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= next_rdata;
    end
  end
endmodule

`default_nettype wire

// [bench/thermal_overload_monitor.sv]
// Port checker for the thermal overload estimator, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module thermal_overload_monitor (
  input wire logic                           i_mclk,
  input wire logic                           i_rst_n,
  input wire logic                           i_sample_valid,
  input wire logic                           i_breaker_open,
  input wire logic                           i_wr,
  input wire logic                           i_rd,
  input wire logic [thermal_pkg::DATA_W-1:0] o_rdata,
  input wire logic                           o_alarm,
  input wire logic                           o_trip,
  input wire logic                           o_high_temp,
  input wire logic                           o_close_inhibit,
  input wire logic [thermal_pkg::HEAT_W-1:0] o_phase_heat_output_1,
  input wire logic [thermal_pkg::HEAT_W-1:0] o_phase_heat_output_2,
  input wire logic [thermal_pkg::HEAT_W-1:0] o_phase_heat_output_3,
  input wire logic [thermal_pkg::HEAT_W-1:0] o_hottest_heat
);
  import thermal_pkg::*;
  logic [HEAT_W-1:0] max12;
  logic [HEAT_W-1:0] max3;

  always_comb begin
    max12 = (o_phase_heat_output_1 > o_phase_heat_output_2) ? o_phase_heat_output_1 : o_phase_heat_output_2;
    max3 = (max12 > o_phase_heat_output_3) ? max12 : o_phase_heat_output_3;
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // Hottest output is registered with the phase outputs; compare only once phases are quiet
  sequence s_quiet;
    $stable(max3) ##1 $stable(max3);
  endsequence

  sequence s_trip_open;
    o_trip && i_breaker_open;
  endsequence

  a_hottest_phase: assert property (s_quiet |-> o_hottest_heat == max3)
    else $error("hottest output differs from largest phase");
  a_alarm_floor: assert property (o_alarm |-> $past(o_hottest_heat) >= LVL_MIN)
    else $error("alarm below lowest alarm level");
  a_high_floor: assert property (o_high_temp && !o_trip |-> $past(o_hottest_heat) >= LVL_MIN)
    else $error("high temperature below lowest level");
  a_inhibit_high: assert property (o_close_inhibit == o_high_temp)
    else $error("close inhibit differs from high temperature");
  a_trip_release: assert property (s_trip_open |=> !o_trip)
    else $error("trip held after breaker opened");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside read answer cycle");
  // Phase outputs trail the model register by one cycle, so the update cause sits two edges back
  a_phase_hold: assert property ($past(i_rst_n) && $past(i_rst_n, 2) && !$past(i_sample_valid, 2)
    && !$past(i_wr, 2) |-> $stable(o_phase_heat_output_1) && $stable(o_phase_heat_output_2)
    && $stable(o_phase_heat_output_3))
    else $error("phase temperature moved without a sample");
  a_reset_clear: assert property (!$past(i_rst_n) |-> max3 == '0 && o_hottest_heat == '0 && !o_trip)
    else $error("outputs not cleared by reset");
endmodule

bind thermal_overload_estimator thermal_overload_monitor u_thermal_overload_monitor (
  .i_mclk, .i_rst_n, .i_sample_valid, .i_breaker_open, .i_wr, .i_rd, .o_rdata, .o_alarm, .o_trip,
  .o_high_temp, .o_close_inhibit, .o_phase_heat_output_1, .o_phase_heat_output_2,
  .o_phase_heat_output_3, .o_hottest_heat
);
`default_nettype wire

// [bench/line_breaker_model.sv]
// Line-side partner: paced phase-current samples and a breaker that opens on a thermal trip.
`timescale 1ns/1ps
`default_nettype none
module line_breaker_model (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_run,
  input  wire logic        i_auto_open,
  input  wire logic [15:0] i_level_a,
  input  wire logic [15:0] i_level_b,
  input  wire logic        i_trip,
  output logic             o_sample_valid,
  output logic [15:0]      o_cur_a,
  output logic [15:0]      o_cur_b,
  output logic [15:0]      o_cur_c,
  output logic             o_breaker_open
);
  logic [1:0] open_dly;

  // Samples every other cycle, far faster than 1 ms, so long heating runs stay cheap
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_sample_valid <= 1'b0;
      open_dly <= 2'h0;
      o_breaker_open <= 1'b0;
    end else begin
      o_sample_valid <= i_run && !o_sample_valid;
      // Mechanism needs a few cycles; stays open until commanded closed
      if (!i_auto_open) begin
        open_dly <= 2'h0;
        o_breaker_open <= 1'b0;
      end else if (i_trip && !o_breaker_open) begin
        open_dly <= open_dly + 2'h1;
        o_breaker_open <= (open_dly == 2'h2);
      end
    end
  end

  assign o_cur_a = i_level_a;
  assign o_cur_b = i_level_b;
  assign o_cur_c = i_level_b >> 1;
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the thermal overload estimator with its line and breaker partner.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import thermal_pkg::*;
  logic              i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic              i_sample_valid, i_breaker_open, run = 1'b0, auto_open = 1'b0;
  logic [CURR_W-1:0] i_phase_current_a, i_phase_current_b, i_phase_current_c;
  logic [15:0]       level_a = 16'h0000, level_b = 16'h0000;
  logic [3:0]        i_user_var = 4'h0;
  logic [ADDR_W-1:0] i_addr = 8'h00;
  logic [DATA_W-1:0] i_wdata = 32'h0, o_rdata;
  logic              o_alarm, o_trip, o_high_temp, o_close_inhibit, o_hot_state;
  logic [HEAT_W-1:0] o_phase_heat_output_1, o_phase_heat_output_2, o_phase_heat_output_3, o_hottest_heat;
  int                fail_count = 0, checked = 0, pulses = 0;

  thermal_overload_estimator u_thermal_overload_estimator (
    .i_mclk, .i_rst_n, .i_sample_valid, .i_phase_current_a, .i_phase_current_b, .i_phase_current_c,
    .i_breaker_open, .i_user_var, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_alarm, .o_trip,
    .o_high_temp, .o_close_inhibit, .o_hot_state, .o_phase_heat_output_1, .o_phase_heat_output_2,
    .o_phase_heat_output_3, .o_hottest_heat
  );
  line_breaker_model u_line_breaker_model (
    .i_mclk, .i_rst_n, .i_run(run), .i_auto_open(auto_open), .i_level_a(level_a), .i_level_b(level_b),
    .i_trip(o_trip), .o_sample_valid(i_sample_valid), .o_cur_a(i_phase_current_a),
    .o_cur_b(i_phase_current_b), .o_cur_c(i_phase_current_c), .o_breaker_open(i_breaker_open)
  );

  always #25 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    if (i_sample_valid === 1'b1) pulses++;
  end

  task automatic print_verdict;
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_flags(input logic [3:0] e);
    chk("flags", {28'h0, e}, {28'h0, o_alarm, o_trip, o_high_temp, o_close_inhibit});
  endtask

  task automatic settle();
    repeat (4) @(posedge i_mclk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk($sformatf("reg %0h", a), e, o_rdata);
  endtask

  task automatic load(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    wr_reg(OFS_PHASE1, {16'h0000, a});
    wr_reg(OFS_PHASE2, {16'h0000, b});
    wr_reg(OFS_PHASE3, {16'h0000, c});
    settle();
  endtask

  task automatic t_regs;
    logic [7:0] a[8] = '{OFS_CTRL, OFS_KFACTOR, OFS_ALARM, OFS_HIGH, OFS_TRIP, OFS_TAU_HEAT, OFS_TAU_COOL,
                         OFS_HOT_LEVEL};
    logic [15:0] e[8] = '{16'h0000, KFAC_DEF, ALARM_DEF, HIGH_DEF, TRIP_DEF, TAU_DEF, TAU_DEF, HOT_DEF};
    logic [7:0] c[6] = '{OFS_KFACTOR, OFS_KFACTOR, OFS_ALARM, OFS_HIGH, OFS_TAU_HEAT, OFS_TAU_COOL};
    logic [15:0] w[6] = '{16'h0000, 16'hffff, 16'h0000, 16'hffff, 16'h0000, 16'hffff};
    logic [15:0] x[6] = '{KFAC_MIN, KFAC_MAX, LVL_MIN, LVL_MAX, TAU_MIN, TAU_MAX};
    for (int i = 0; i < 8; i++) begin
      chk_reg(a[i], {16'h0000, e[i]});
    end
    chk_reg(8'h3c, 32'h0);
    wr_reg(OFS_STATUS, 32'hffff_ffff);
    chk_reg(OFS_STATUS, 32'h0);
    // Leaves the fastest heating and slowest cooling constants for the model runs later
    for (int i = 0; i < 6; i++) begin
      wr_reg(c[i], {16'h0000, w[i]});
      chk_reg(c[i], {16'h0000, x[i]});
    end
    wr_reg(OFS_KFACTOR, {16'h0000, KFAC_DEF});
    wr_reg(OFS_ALARM, {16'h0000, ALARM_DEF});
    wr_reg(OFS_HIGH, {16'h0000, HIGH_DEF});
  endtask

  task automatic t_disabled;
    wr_reg(OFS_CTRL, 32'h1);
    load(16'h03e8, 16'h0064, 16'h00c8);
    chk_flags(4'h0);
    wr_reg(OFS_CTRL, 32'h2);
    settle();
    chk_flags(4'h0);
    chk("hottest", 32'h3e8, {16'h0000, o_hottest_heat});
    chk_reg(OFS_PHASE2, 32'h64);
    chk("phase 3", 32'hc8, {16'h0000, o_phase_heat_output_3});
  endtask

  task automatic t_feeder;
    load(16'h0000, 16'h0000, 16'h0000);
    wr_reg(OFS_CTRL, 32'h3);
    load(16'h0000, 16'h0398, 16'h0000);
    chk_flags(4'h8);
    load(16'h0000, 16'h0398, 16'h03e8);
    chk_flags(4'hf);
    auto_open <= 1'b1;
    repeat (8) @(posedge i_mclk);
    #1;
    chk_flags(4'hb);
    load(16'h03c0, 16'h0000, 16'h0000);
    chk_flags(4'hb);
    load(16'h03a2, 16'h0000, 16'h0000);
    chk_flags(4'h8);
    auto_open <= 1'b0;
    wr_reg(OFS_TRIPS, 32'hffff);
    chk_reg(OFS_PICKUPS, 32'h1);
    chk_reg(OFS_TRIPS, 32'h1);
    chk_reg(OFS_STATUS, 32'h1);
    wr_reg(OFS_CTRL, 32'h7);
    load(16'h03b6, 16'h0000, 16'h0000);
    chk_flags(4'hb);
    load(16'h03b5, 16'h0000, 16'h0000);
    chk_flags(4'h8);
  endtask

  task automatic t_block;
    wr_reg(OFS_CTRL, 32'h17);
    i_user_var <= 4'h1;
    load(16'h03e8, 16'h0000, 16'h0000);
    for (int s = 1; s <= 4; s++) begin
      wr_reg(OFS_CTRL, 32'(s * 16 + 7));
      i_user_var <= 4'(1 << (s - 1));
      settle();
      chk_flags(4'h3);
      @(posedge i_mclk);
      i_user_var <= 4'h0;
      settle();
      chk_flags(4'hf);
    end
    wr_reg(OFS_CTRL, 32'h7);
    i_user_var <= 4'hf;
    settle();
    chk_flags(4'hf);
    @(posedge i_mclk);
    i_user_var <= 4'h0;
  endtask

  task automatic t_heating;
    int n;
    logic [15:0] h;
    wr_reg(OFS_CTRL, 32'h3);
    load(16'h0000, 16'h0000, 16'h0000);
    n = pulses;
    level_a <= 16'h1f40;
    level_b <= 16'h07d0;
    run <= 1'b1;
    repeat (400) @(posedge i_mclk);
    run <= 1'b0;
    settle();
    n = pulses - n;
    h = o_phase_heat_output_1;
    chk("heating", 32'h1, {31'h0, h >= n * 9 / 10 && h <= n * 6 / 5});
    chk("phase order", 32'h1, {31'h0, h > o_phase_heat_output_2});
    level_a <= 16'h0000;
    level_b <= 16'h0000;
    run <= 1'b1;
    repeat (400) @(posedge i_mclk);
    run <= 1'b0;
    settle();
    chk("cooling", 32'h1, {31'h0, o_phase_heat_output_1 <= h});
  endtask

  task automatic t_machine;
    wr_reg(OFS_CTRL, 32'hb);
    level_a <= 16'h03e8;
    run <= 1'b1;
    load(16'h03f2, 16'h0000, 16'h0000);
    chk("trip rated", 32'h0, {31'h0, o_trip});
    chk("hot state", 32'h1, {31'h0, o_hot_state});
    level_a <= 16'h04b0;
    settle();
    chk("trip over", 32'h1, {31'h0, o_trip});
    level_a <= 16'h0000;
    load(16'h01f4, 16'h0000, 16'h0000);
    repeat (4000) @(posedge i_mclk);
    #1;
    chk("slow cooling", 32'h1, {31'h0, o_phase_heat_output_1 >= 16'h01f3});
    run <= 1'b0;
    load(16'h0000, 16'h0000, 16'h0000);
    chk("hot cleared", 32'h0, {31'h0, o_hot_state});
  endtask

  initial begin
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    #1;
    chk("phase 1 start", 32'h0, {16'h0000, o_phase_heat_output_1});
    t_regs();
    t_disabled();
    t_feeder();
    t_block();
    t_heating();
    t_machine();
    print_verdict();
  end

  initial begin
    repeat (100000) @(posedge i_mclk);
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
